/* sar_adc_sequencer.sv */
`timescale 1ns/1ps
// Notes on behaviour
// R01: Only the channel in the channel select register is converted.
// R02: Each conversion samples for a fixed time, then holds until done.
// R03: First trial sets bit 7, tap at half reference.
// R04: Bit 7 stays set if input >= half tap, else cleared.
// R05: Bit 6 trial uses 3/4 or 1/4 tap; kept when input >= tap.
// R06: Binary search continues to bit 0; then value goes to result.
// R07: End request is raised in the same step the result latches.
// R08: Conversions repeat back to back until enable is cleared.
// R09: Mode or channel write while enabled restarts from sampling.
// R10: Result register has no reset value.
// R11: End flag is set on every completed conversion for polling.
// R12: Ideal code is INT(vin/ref*256+0.5), set by tap offsets.
// R13: No hardware trigger; only software enable starts conversion.
// R14: Next conversion starts immediately after one completes.
// R15: Mode write with enable low stops at once, no result or request.
// R16: Software discards the first result after enabling.
// R17: Result read at completion returns the old value.
// R18: Register write at completion wins; no result, no request.
// R19: Sampling takes at least a ninth of conversion time.
// R20: Standby stops the converter; enable low turns off the string.
// R21: Time field picks 144,120,96,72,60 or 48 clocks.
// R22: Two-bit channel field picks input 0 to 3; resets to zero.
// R23: Channel writes leave the end flag alone; software clears it.
// R24: Time splits into one sampling interval and eight equal trials.
// R25: Enable rising starts a fresh conversion from sampling.
module sar_adc_sequencer
   import sar_adc_pkg::*;
(
   input wire logic clk,
   input wire logic reset,
   input wire logic mode_wr,
   input wire logic [DATA_W-1:0] mode_wdata,
   input wire logic chan_wr,
   input wire logic [DATA_W-1:0] chan_wdata,
   input wire logic result_rd,
   input wire logic flag_clear,
   input wire logic standby,
   input wire logic comp_ge,
   output logic [DATA_W-1:0] converter_mode_reg,
   output logic [DATA_W-1:0] channel_select_reg,
   output logic [DATA_W-1:0] conversion_result_reg,
   output logic [DATA_W-1:0] result_rdata,
   output logic conversion_end_request,
   output logic conversion_end_flag,
   output logic [DATA_W-1:0] tap_code,
   output logic [CHAN_W-1:0] analog_input_sel,
   output logic sample_enable,
   output logic ref_string_enable,
   output logic busy
);

   typedef struct packed {
      conv_state_t state;
      logic [CNT_W-1:0] cnt;
      logic [DATA_W-1:0] mode;
      logic [DATA_W-1:0] chan;
      logic [DATA_W-1:0] result;
      logic [DATA_W-1:0] rd_data;
      logic end_req;
      logic flag;
      logic [CHAN_W-1:0] in_sel;
      logic sample;
      logic ref_on;
      logic busy;
   } seq_state_t;

   seq_state_t st_r;
   seq_state_t st_nxt;
   sar_step_if sar ();

   logic en_new;
   logic [TSEL_W-1:0] tsel_new;
   logic [DATA_W-1:0] chan_new;
   logic reg_write;
   logic complete;
   logic start_sar;
   logic step_sar;

   sar_register u_sar (
      .clk(clk),
      .reset(reset),
      .sar(sar)
   );

   assign sar.start = start_sar;
   assign sar.step = step_sar;
   assign sar.comp_ge = comp_ge;

   always_comb
   begin
      st_nxt = st_r;
      st_nxt.end_req = 1'b0;
      start_sar = 1'b0;
      step_sar = 1'b0;
      complete = 1'b0;
      reg_write = mode_wr | chan_wr;

      if (mode_wr)
      begin
         st_nxt.mode = mode_wdata & MODE_WMASK;
      end
      if (chan_wr)
      begin
         st_nxt.chan = chan_wdata & CHAN_WMASK; // R22
      end
      en_new = st_nxt.mode[EN_BIT];
      tsel_new = st_nxt.mode[TSEL_LSB +: TSEL_W]; // R21
      chan_new = st_nxt.chan;

      // Register output at read time is still the old result
      if (result_rd)
      begin
         st_nxt.rd_data = st_r.result; // R17
      end

      if (standby || !en_new)
      begin
         // Abort with nothing latched and no request
         st_nxt.state = ST_IDLE; // R15 R20
         st_nxt.cnt = CNT_LAST;
      end
      else if (reg_write || st_r.state == ST_IDLE)
      begin
         // Any write wins over a completion in the same cycle
         st_nxt.state = ST_SAMPLE; // R09 R13 R18 R25
         st_nxt.cnt = sample_cycles(tsel_new); // R19 R24
      end
      else
      begin
         unique case (st_r.state)
            ST_SAMPLE:
            begin
               if (st_r.cnt == CNT_LAST)
               begin
                  st_nxt.state = ST_TRIAL; // R02
                  st_nxt.cnt = trial_cycles(tsel_new); // R24
                  start_sar = 1'b1; // R03
               end
               else
               begin
                  st_nxt.cnt = st_r.cnt - CNT_LAST;
               end
            end
            ST_TRIAL:
            begin
               if (st_r.cnt == CNT_LAST)
               begin
                  step_sar = 1'b1; // R04 R05 R06
                  if (sar.last)
                  begin
                     complete = 1'b1;
                     st_nxt.result = sar.decided; // R06
                     st_nxt.end_req = 1'b1; // R07
                     st_nxt.state = ST_SAMPLE; // R08 R14
                     st_nxt.cnt = sample_cycles(tsel_new);
                  end
                  else
                  begin
                     st_nxt.cnt = trial_cycles(tsel_new);
                  end
               end
               else
               begin
                  st_nxt.cnt = st_r.cnt - CNT_LAST;
               end
            end
            ST_IDLE:
            begin
               st_nxt.cnt = CNT_LAST;
            end
         endcase
      end

      // A completion in the clearing cycle keeps the flag set
      st_nxt.flag = complete | (st_r.flag & ~flag_clear); // R11 R23
      st_nxt.in_sel = chan_new[CHAN_LSB +: CHAN_W]; // R01
      st_nxt.sample = (st_nxt.state == ST_SAMPLE); // R02
      st_nxt.ref_on = en_new; // R20
      st_nxt.busy = (st_nxt.state != ST_IDLE);

      if (reset)
      begin
         // Result keeps whatever it holds
         st_nxt.state = ST_IDLE;
         st_nxt.cnt = CNT_LAST;
         st_nxt.mode = MODE_RESET;
         st_nxt.chan = CHAN_RESET; // R22
         st_nxt.result = st_r.result; // R10
         st_nxt.rd_data = RESULT_ZERO;
         st_nxt.end_req = 1'b0;
         st_nxt.flag = 1'b0;
         st_nxt.in_sel = CHAN_RESET[CHAN_LSB +: CHAN_W];
         st_nxt.sample = 1'b0;
         st_nxt.ref_on = 1'b0;
         st_nxt.busy = 1'b0;
      end
   end

   always_ff @(posedge clk)
   begin
      st_r <= st_nxt;
   end

   assign converter_mode_reg = st_r.mode;
   assign channel_select_reg = st_r.chan;
   assign conversion_result_reg = st_r.result;
   assign result_rdata = st_r.rd_data;
   assign conversion_end_request = st_r.end_req;
   assign conversion_end_flag = st_r.flag;
   // Tap code plus a half-step string offset gives rounding
   assign tap_code = sar.approx; // R12
   assign analog_input_sel = st_r.in_sel;
   assign sample_enable = st_r.sample;
   assign ref_string_enable = st_r.ref_on;
   assign busy = st_r.busy;

endmodule

/* sar_adc_pkg.sv */
package sar_adc_pkg;

   localparam int DATA_W = 8;
   localparam int CHAN_W = 2;
   localparam int TSEL_W = 3;
   localparam int CNT_W = 8;
   localparam int BIT_IDX_W = 3;

   // Converter mode register layout
   localparam int EN_BIT = 7;
   localparam int TSEL_LSB = 3;
   localparam logic [DATA_W-1:0] MODE_RESET = 8'h00;
   localparam logic [DATA_W-1:0] MODE_WMASK = 8'hb8;

   // Channel select register layout
   localparam int CHAN_LSB = 0;
   localparam logic [DATA_W-1:0] CHAN_RESET = 8'h00;
   localparam logic [DATA_W-1:0] CHAN_WMASK = 8'h03;

   // Successive approximation
   localparam logic [DATA_W-1:0] SAR_FIRST = 8'h80;
   localparam logic [BIT_IDX_W-1:0] MSB_IDX = 3'h7;
   localparam logic [BIT_IDX_W-1:0] LSB_IDX = 3'h0;
   localparam logic [DATA_W-1:0] RESULT_ZERO = 8'h00;

   // Conversion time select codes and totals in main clock periods
   localparam logic [TSEL_W-1:0] TSEL_144 = 3'h0;
   localparam logic [TSEL_W-1:0] TSEL_120 = 3'h1;
   localparam logic [TSEL_W-1:0] TSEL_96 = 3'h2;
   localparam logic [TSEL_W-1:0] TSEL_72 = 3'h4;
   localparam logic [TSEL_W-1:0] TSEL_60 = 3'h5;
   localparam logic [TSEL_W-1:0] TSEL_48 = 3'h6;
   localparam logic [CNT_W-1:0] CONV_144 = 8'h90;
   localparam logic [CNT_W-1:0] CONV_120 = 8'h78;
   localparam logic [CNT_W-1:0] CONV_96 = 8'h60;
   localparam logic [CNT_W-1:0] CONV_72 = 8'h48;
   localparam logic [CNT_W-1:0] CONV_60 = 8'h3c;
   localparam logic [CNT_W-1:0] CONV_48 = 8'h30;

   // Eight trials plus one sampling share make nine slots
   localparam logic [CNT_W-1:0] TRIAL_DIV = 8'h09;
   localparam logic [CNT_W-1:0] TRIALS = 8'h08;
   localparam logic [CNT_W-1:0] CNT_LAST = 8'h01;

   typedef enum logic [1:0] {ST_IDLE, ST_SAMPLE, ST_TRIAL} conv_state_t;

   function automatic logic [CNT_W-1:0] conv_cycles(
      input logic [TSEL_W-1:0] tsel);
      logic [CNT_W-1:0] c;
      c = CONV_144;
      unique case (tsel)
         TSEL_120: c = CONV_120;
         TSEL_96: c = CONV_96;
         TSEL_72: c = CONV_72;
         TSEL_60: c = CONV_60;
         TSEL_48: c = CONV_48;
         default: c = CONV_144;
      endcase
      return c;
   endfunction

   function automatic logic [CNT_W-1:0] trial_cycles(
      input logic [TSEL_W-1:0] tsel);
      return conv_cycles(tsel) / TRIAL_DIV;
   endfunction

   function automatic logic [CNT_W-1:0] sample_cycles(
      input logic [TSEL_W-1:0] tsel);
      logic [CNT_W-1:0] t;
      t = trial_cycles(tsel);
      return CNT_W'(conv_cycles(tsel) - CNT_W'(t * TRIALS));
   endfunction

endpackage

/* sar_step_if.sv */
`timescale 1ns/1ps
interface sar_step_if;
   import sar_adc_pkg::*;
   logic start;
   logic step;
   logic comp_ge;
   logic [DATA_W-1:0] approx;
   logic [DATA_W-1:0] decided;
   logic last;

   modport ctrl (
      output start,
      output step,
      output comp_ge,
      input approx,
      input decided,
      input last
   );

   modport engine (
      input start,
      input step,
      input comp_ge,
      output approx,
      output decided,
      output last
   );
endinterface

/* sar_register.sv */
`timescale 1ns/1ps
module sar_register
   import sar_adc_pkg::*;
(
   input wire logic clk,
   input wire logic reset,
   sar_step_if.engine sar
);

   typedef struct packed {
      logic [DATA_W-1:0] approx;
      logic [BIT_IDX_W-1:0] idx;
   } sar_state_t;

   sar_state_t st_r;
   sar_state_t st_nxt;
   logic [DATA_W-1:0] with_decision;

   always_comb
   begin
      with_decision = st_r.approx;
      with_decision[st_r.idx] = sar.comp_ge;
      st_nxt = st_r;
      if (reset)
      begin
         st_nxt.approx = RESULT_ZERO;
         st_nxt.idx = MSB_IDX;
      end
      else if (sar.start)
      begin
         st_nxt.approx = SAR_FIRST; // R03
         st_nxt.idx = MSB_IDX;
      end
      else if (sar.step)
      begin
         st_nxt.approx = with_decision; // R04 R05
         if (st_r.idx != LSB_IDX)
         begin
            st_nxt.approx[st_r.idx - 3'h1] = 1'b1; // R06
            st_nxt.idx = st_r.idx - 3'h1;
         end
      end
   end

   always_ff @(posedge clk)
   begin
      st_r <= st_nxt;
   end

   // Approximation value is the resistor string tap code
   assign sar.approx = st_r.approx;
   assign sar.decided = with_decision;
   assign sar.last = (st_r.idx == LSB_IDX);

endmodule

/* analog_model.sv */
`timescale 1ns/1ps
module analog_model
   import sar_adc_pkg::*;
(
   input wire logic clk,
   input wire logic sample_enable,
   input wire logic [CHAN_W-1:0] analog_input_sel,
   input wire logic [DATA_W-1:0] tap_code,
   input wire logic [3:0][DATA_W-1:0] level,
   output logic comp_ge
);
   logic [DATA_W-1:0] held;
   initial held = 8'h00;
   // Last sampling edge wins, then held
   always @(posedge clk)
      if (sample_enable)
         held <= level[analog_input_sel];
   assign comp_ge = held >= tap_code;
endmodule

/* sar_adc_sva.sv */
`timescale 1ns/1ps
module sar_adc_sva
   import sar_adc_pkg::*;
(
   input wire logic clk,
   input wire logic reset,
   input wire logic mode_wr,
   input wire logic [DATA_W-1:0] mode_wdata,
   input wire logic chan_wr,
   input wire logic [DATA_W-1:0] chan_wdata,
   input wire logic result_rd,
   input wire logic standby,
   input wire logic [DATA_W-1:0] conversion_result_reg,
   input wire logic [DATA_W-1:0] result_rdata,
   input wire logic conversion_end_request,
   input wire logic conversion_end_flag,
   input wire logic [DATA_W-1:0] tap_code,
   input wire logic [CHAN_W-1:0] analog_input_sel,
   input wire logic sample_enable,
   input wire logic ref_string_enable,
   input wire logic busy
);
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   property p_pulse;
      conversion_end_request |=> !conversion_end_request;
   endproperty
   a_pulse: assert property (p_pulse) else $error("long end pulse");
   property p_flag;
      conversion_end_request |-> conversion_end_flag;
   endproperty
   a_flag: assert property (p_flag) else $error("flag not set");
   property p_again;
      conversion_end_request |-> sample_enable && busy;
   endproperty
   a_again: assert property (p_again) else $error("gap after end");
   property p_tap;
      $fell(sample_enable) && busy |-> tap_code == 8'h80;
   endproperty
   a_tap: assert property (p_tap) else $error("first tap wrong");
   property p_stop;
      mode_wr && !mode_wdata[7] |=> !busy && !conversion_end_request;
   endproperty
   a_stop: assert property (p_stop) else $error("stop failed");
   property p_restart;
      mode_wr && mode_wdata[7] && !standby
         |=> sample_enable && !conversion_end_request;
   endproperty
   a_restart: assert property (p_restart) else $error("no restart");
   property p_chan;
      chan_wr && !mode_wr && ref_string_enable && !standby |=> sample_enable
         && analog_input_sel == $past(chan_wdata[1:0]);
   endproperty
   a_chan: assert property (p_chan) else $error("channel restart");
   property p_read;
      result_rd |=> result_rdata == $past(conversion_result_reg);
   endproperty
   a_read: assert property (p_read) else $error("read not old");
   property p_standby;
      standby |=> !busy;
   endproperty
   a_standby: assert property (p_standby) else $error("runs in standby");
endmodule
bind sar_adc_sequencer sar_adc_sva chk_u (.*);

/* tb.sv */
`timescale 1ns/1ps
module tb;
   import sar_adc_pkg::*;
   logic clk, reset, mode_wr, chan_wr, result_rd, flag_clear, standby;
   logic comp_ge, req, flag, smp, refe, busy;
   logic [7:0] mode_wdata, chan_wdata, mode_q, chan_q, res, rdata, tap, l2, old;
   logic [1:0] sel;
   logic [3:0][7:0] level;
   logic [31:0] lfsr = 32'he3c1;
   int errors, checked, ch, t, exp_v;
   sar_adc_sequencer dut_u (.clk, .reset, .mode_wr, .mode_wdata, .chan_wr,
      .chan_wdata, .result_rd, .flag_clear, .standby, .comp_ge,
      .converter_mode_reg(mode_q), .channel_select_reg(chan_q),
      .conversion_result_reg(res), .result_rdata(rdata),
      .conversion_end_request(req), .conversion_end_flag(flag),
      .tap_code(tap), .analog_input_sel(sel), .sample_enable(smp),
      .ref_string_enable(refe), .busy);
   analog_model part_u (.clk, .sample_enable(smp), .analog_input_sel(sel),
      .tap_code(tap), .level, .comp_ge);
   function automatic logic [7:0] rnd();
      lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
      return lfsr[7:0];
   endfunction
   function automatic int exp_t(input int c);
      int v[8] = '{144, 120, 96, 144, 72, 60, 48, 144};
      return v[c];
   endfunction
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp)
      begin
         errors++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic wr(input logic m, input logic [7:0] d);
      mode_wr = m;
      chan_wr = !m;
      mode_wdata = d;
      chan_wdata = d;
      cyc(1);
      mode_wr = 0;
      chan_wr = 0;
   endtask
   // Cycles until the next end request, capped so a hang cannot stall
   task automatic wait_req(output int n);
      n = 0;
      do
      begin
         cyc(1);
         n++;
      end while (req !== 1'b1 && n < 400);
   endtask
   // Reference copy of the hold stage: the last level seen while sampling
   always @(posedge clk)
      if (smp === 1'b1)
         exp_v <= level[sel];
   // Every finished result is held against the reference
   always @(negedge clk)
      if (req === 1'b1)
         check(res, exp_v);
   task automatic finish_test;
      $display("checked %0d errors %0d", checked, errors);
      if (errors == 0 && checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   initial
   begin
      clk = 0;
      forever #25 clk = ~clk;
   end
   initial
   begin
      cyc(20000);
      errors++;
      finish_test;
   end
   initial
   begin
      {reset, mode_wr, chan_wr, result_rd, flag_clear, standby} = 6'h20;
      {mode_wdata, chan_wdata, level} = '0;
      cyc(10);
      reset = 0;
      check(mode_q, 0);
      check(chan_q, 0);
      check(busy, 0);
      for (int c = 0; c < 8; c++)
      begin
         ch = c % 4;
         for (int i = 0; i < 4; i++)
            level[i] = rnd();
         wr(0, 8'(ch));
         // Let an edge pass so no strobe is driven twice in one step
         cyc(1);
         wr(1, 8'hc7 | 8'(c << 3));
         check(mode_q, 8'h80 | 8'(c << 3));
         // First result after enabling is not trusted
         wait_req(t);
         wait_req(t);
         check(t, exp_t(c));
         check(res, level[ch]);
         check(flag, 1);
      end
      $display("period and code test done");
      wait_req(t);
      cyc(20);
      wr(1, 8'h00);
      check(busy, 0);
      check(refe, 0);
      wait_req(t);
      check(t, 400);
      wr(1, 8'hb0);
      cyc(5);
      standby = 1;
      cyc(2);
      check(busy, 0);
      standby = 0;
      $display("stop and standby test done");
      wait_req(t);
      l2 = rnd();
      level[ch] = l2;
      cyc(47);
      result_rd = 1;
      old = res;
      cyc(1);
      result_rd = 0;
      check(rdata, old);
      check(res, l2);
      check(req, 1);
      level[ch] = ~l2;
      flag_clear = 1;
      cyc(1);
      flag_clear = 0;
      cyc(46);
      ch = (ch + 1) % 4;
      wr(0, 8'hfc | 8'(ch));
      check(res, l2);
      check(req, 0);
      check(flag, 0);
      check(sel, ch);
      check(chan_q, ch);
      wait_req(t);
      check(t, 48);
      check(res, level[ch]);
      wr(0, 8'(ch));
      check(flag, 1);
      $display("collision test done");
      finish_test;
   end
endmodule
